// file: logic/dtc_mc_end.sv
// controller end: apb registers, pin hold timing, read guard and command issue
module dtc_mc_end
  import dtc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // link to the memory
  dtc_link_if.mc           link
);

  // software registers
  logic [2:0]  ctrl_r, ctrl_nxt;
  logic [17:0] mrs_r, mrs_nxt;
  logic [12:0] tim_r, tim_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  // pending work and timing
  logic wr_p_r, wr_p_nxt, ch_p_r, ch_p_nxt, rd_p_r, rd_p_nxt, ms_p_r, ms_p_nxt, dis_p_r, dis_p_nxt;
  logic dll_d_r;
  logic [ADDR_W-1:0] sh0_r, sh0_nxt, sh2_r, sh2_nxt;
  logic [HOLD_W-1:0] hold_r, hold_nxt, want_hold;
  logic [LAT_W-1:0]  low_r, low_nxt;
  logic [POST_W-1:0] post_r, post_nxt;
  // link output flops
  logic pin_r, pin_nxt, wr_r, wr_nxt, ch_r, ch_nxt, rd_r, rd_nxt, ms_r, ms_nxt;
  logic [1:0] sel_r, sel_nxt;
  logic [ADDR_W-1:0] adr_r, adr_nxt;
  // decode
  logic acc_wr, hit, want, rd_ok, dis_go, ms_go, rd_go, wr_go;

  assign acc_wr    = psel_i & penable_i & pwrite_i;
  assign hit       = (paddr_i == REG_CTRL) || (paddr_i == REG_CMD) || (paddr_i == REG_MRS) ||
                     (paddr_i == REG_TIMING) || (paddr_i == REG_STATUS);
  assign pready_o  = 1'b1;  // zero wait states, every access phase ends at once
  assign pslverr_o = psel_i & penable_i & ~hit;
  assign prdata_o  = prdata_r;

  // one command per cycle; disabling dynamic mode beats everything
  always_comb begin
    dis_go = dis_p_r;
    ms_go  = ms_p_r & ~dis_go;
    // read only after the pin has been low past the off latency plus a cycle
    rd_ok  = ~pin_r & (low_r > tim_r[LAT_W-1:0]);
    rd_go  = rd_p_r & rd_ok & ~dis_go & ~ms_go;
    wr_go  = wr_p_r & ~dis_go & ~ms_go & ~rd_go;
    // direct termination is not used with the loop off or around reads
    want   = ctrl_r[CTRL_REQ] & ~ctrl_r[CTRL_DLL_OFF] & ~rd_p_r & (post_r == '0);
  end

  // software registers, pending flags, hold and read timing
  always_comb begin
    ctrl_nxt = ctrl_r;
    mrs_nxt = mrs_r;
    tim_nxt = tim_r;
    prdata_nxt = prdata_r;
    wr_p_nxt = wr_p_r & ~wr_go;
    ch_p_nxt = ch_p_r;
    rd_p_nxt = rd_p_r & ~rd_go;
    ms_p_nxt = ms_p_r & ~ms_go;
    dis_p_nxt = (dis_p_r & ~dis_go) | (ctrl_r[CTRL_DLL_OFF] & ~dll_d_r);
    if (acc_wr) begin
      unique case (paddr_i)
        REG_CTRL:   ctrl_nxt = pwdata_i[2:0];
        REG_MRS:    mrs_nxt = pwdata_i[17:0];
        REG_TIMING: tim_nxt = pwdata_i[12:0];
        REG_CMD: begin
          // a new request sets its flag even in the cycle the old one issues
          wr_p_nxt = wr_p_nxt | pwdata_i[CMD_WR];
          rd_p_nxt = rd_p_nxt | pwdata_i[CMD_RD];
          ms_p_nxt = ms_p_nxt | pwdata_i[CMD_MRS];
          if (pwdata_i[CMD_WR]) ch_p_nxt = pwdata_i[CMD_CHOP];
        end
        default: ;
      endcase
    end
    if (psel_i & ~penable_i) begin
      unique case (paddr_i)
        REG_CTRL:   prdata_nxt = {29'h0, ctrl_r};
        REG_MRS:    prdata_nxt = {14'h0, mrs_r};
        REG_TIMING: prdata_nxt = {19'h0, tim_r};
        REG_STATUS: prdata_nxt = {25'h0, post_r != '0, dis_p_r, ms_p_r, rd_p_r, wr_p_r,
                                  hold_r != '0, pin_r};
        default:    prdata_nxt = '0;
      endcase
    end
    // pin may only fall once every hold count has run out
    pin_nxt = (pin_r & (hold_r != '0)) | want;
    hold_nxt = (hold_r != '0) ? hold_r - 3'h1 : '0;
    want_hold = '0;
    if (pin_nxt & ~pin_r) want_hold = MIN_CONTROL_HIGH_SHORT - 3'h1;
    if (pin_nxt & wr_go) begin
      if (dtc_is_chop(sh0_r, ch_p_r)) begin
        if (want_hold < MIN_CONTROL_HIGH_SHORT - 3'h1) want_hold = MIN_CONTROL_HIGH_SHORT - 3'h1;
      end else begin
        want_hold = MIN_CONTROL_HIGH_LONG - 3'h1;
      end
    end
    if (want_hold > hold_nxt) hold_nxt = want_hold;
    low_nxt = pin_r ? '0 : ((low_r == '1) ? low_r : low_r + 5'h01);
    post_nxt = (post_r != '0) ? post_r - 6'h01 : '0;
    if (rd_go) post_nxt = {1'b0, tim_r[TIM_RD_LSB +: LAT_W]} + READ_TAIL;
    // command outputs
    wr_nxt = wr_go;
    ch_nxt = wr_go & ch_p_r;
    rd_nxt = rd_go;
    ms_nxt = dis_go | ms_go;
    sel_nxt = sel_r;
    adr_nxt = adr_r;
    sh0_nxt = sh0_r;
    sh2_nxt = sh2_r;
    if (dis_go) begin
      sel_nxt = SEL_MODE2;
      adr_nxt = sh2_r;
      adr_nxt[WRS_B10] = 1'b0;
      adr_nxt[WRS_B9] = 1'b0;
      sh2_nxt = adr_nxt;
    end else if (ms_go) begin
      sel_nxt = mrs_r[MRS_SEL_LSB +: 2];
      adr_nxt = mrs_r[ADDR_W-1:0];
      if (sel_nxt == SEL_MODE0) sh0_nxt = adr_nxt;
      if (sel_nxt == SEL_MODE2) sh2_nxt = adr_nxt;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r   <= '0;
      mrs_r    <= '0;
      tim_r    <= '0;
      prdata_r <= '0;
      wr_p_r   <= 1'b0;
      ch_p_r   <= 1'b0;
      rd_p_r   <= 1'b0;
      ms_p_r   <= 1'b0;
      dis_p_r  <= 1'b0;
      dll_d_r  <= 1'b0;
      sh0_r    <= '0;
      sh2_r    <= '0;
      hold_r   <= '0;
      low_r    <= '0;
      post_r   <= '0;
      pin_r    <= 1'b0;
      wr_r     <= 1'b0;
      ch_r     <= 1'b0;
      rd_r     <= 1'b0;
      ms_r     <= 1'b0;
      sel_r    <= '0;
      adr_r    <= '0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      mrs_r    <= mrs_nxt;
      tim_r    <= tim_nxt;
      prdata_r <= prdata_nxt;
      wr_p_r   <= wr_p_nxt;
      ch_p_r   <= ch_p_nxt;
      rd_p_r   <= rd_p_nxt;
      ms_p_r   <= ms_p_nxt;
      dis_p_r  <= dis_p_nxt;
      dll_d_r  <= ctrl_r[CTRL_DLL_OFF];
      sh0_r    <= sh0_nxt;
      sh2_r    <= sh2_nxt;
      hold_r   <= hold_nxt;
      low_r    <= low_nxt;
      post_r   <= post_nxt;
      pin_r    <= pin_nxt;
      wr_r     <= wr_nxt;
      ch_r     <= ch_nxt;
      rd_r     <= rd_nxt;
      ms_r     <= ms_nxt;
      sel_r    <= sel_nxt;
      adr_r    <= adr_nxt;
    end
  end

  // link drive from flops
  assign link.termination_control_pin = pin_r;
  assign link.wr_cmd       = wr_r;
  assign link.chop_otf     = ch_r;
  assign link.rd_cmd       = rd_r;
  assign link.mrs_cmd      = ms_r;
  assign link.mrs_sel      = sel_r;
  assign link.mrs_addr     = adr_r;
  assign link.self_refresh = ctrl_r[CTRL_SREF];

endmodule : dtc_mc_end

// file: logic/dtc_pkg.sv
// package: constants, mode register fields and latency decode for termination control
// Behaviour
// - controller keeps pin high four cycles minimum
// - write with pin high extends hold 4/6
// - pin falls only after every hold expires
// - termination on after write latency minus two
// - termination off after write latency minus two
// - controller drops pin well before read preamble
// - controller re-enables only after read postamble
// - termination on only once data drive stops
// - dynamic mode when either write-strength bit set
// - strengths taken from first/second mode registers
// - nominal strength, pin-timed, outside writes
// - write strength write latency minus two after write
// - nominal again after off latency plus 4/6
// - controller clears write-strength bits with loop off
// - additive latency included in termination latency
// - pin ignored when disabled or self-refreshing
package dtc_pkg;

  // storage and field widths
  localparam int DEPTH  = 32;
  localparam int LAT_W  = 5;
  localparam int ADDR_W = 16;
  localparam int HOLD_W = 3;
  localparam int POST_W = 6;

  // mode register selects
  localparam logic [1:0] SEL_MODE0 = 2'h0;
  localparam logic [1:0] SEL_MODE1 = 2'h1;
  localparam logic [1:0] SEL_MODE2 = 2'h2;

  // first mode register: nominal strength bits and additive latency field
  localparam int NOM_B2  = 2;
  localparam int NOM_B6  = 6;
  localparam int NOM_B9  = 9;
  localparam int ADD_LSB = 3;
  // second mode register: write strength bits and cas write latency field
  localparam int WRS_B9  = 9;
  localparam int WRS_B10 = 10;
  localparam int CWL_LSB = 3;
  // zero mode register: cas latency and burst length fields
  localparam int CL_LSB  = 4;
  localparam int BURST_LSB = 0;

  // burst length field codes
  localparam logic [1:0] BURST_FIXED8 = 2'h0;
  localparam logic [1:0] BURST_OTF    = 2'h1;
  localparam logic [1:0] BURST_FIXED4 = 2'h2;
  // additive latency field codes
  localparam logic [1:0] ADD_CL_M1 = 2'h1;
  localparam logic [1:0] ADD_CL_M2 = 2'h2;

  // latency figures in clock cycles
  localparam logic [LAT_W-1:0] CWL_BASE   = 5'h05;
  localparam logic [LAT_W-1:0] CL_BASE    = 5'h04;
  localparam logic [LAT_W-1:0] ONE_CYCLE  = 5'h01;
  localparam logic [LAT_W-1:0] TWO_CYCLES = 5'h02;
  localparam logic [LAT_W-1:0] LAT_OFFSET = 5'h02;
  localparam logic [HOLD_W-1:0] MIN_CONTROL_HIGH_SHORT = 3'h4;
  localparam logic [HOLD_W-1:0] MIN_CONTROL_HIGH_LONG  = 3'h6;
  localparam logic [POST_W-1:0] READ_TAIL = 6'h05;

  // controller register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CMD    = 8'h04;
  localparam logic [7:0] REG_MRS    = 8'h08;
  localparam logic [7:0] REG_TIMING = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  // register bit positions
  localparam int CTRL_REQ = 0;
  localparam int CTRL_SREF = 1;
  localparam int CTRL_DLL_OFF = 2;
  localparam int CMD_WR = 0;
  localparam int CMD_CHOP = 1;
  localparam int CMD_RD = 2;
  localparam int CMD_MRS = 3;
  localparam int MRS_SEL_LSB = 16;
  localparam int TIM_RD_LSB = 8;

  typedef enum logic {STR_NOMINAL, STR_WRITE} dtc_strength_e;

  // termination latency: cas write latency plus additive latency minus two
  function automatic logic [LAT_W-1:0] dtc_term_latency(input logic [ADDR_W-1:0] mr0,
                                                        input logic [ADDR_W-1:0] mr1,
                                                        input logic [ADDR_W-1:0] mr2);
    logic [LAT_W-1:0] cas_write_latency;
    logic [LAT_W-1:0] cl;
    logic [LAT_W-1:0] add;
    cas_write_latency = CWL_BASE + {2'h0, mr2[CWL_LSB +: 3]};
    cl  = CL_BASE + {2'h0, mr0[CL_LSB +: 3]};
    unique case (mr1[ADD_LSB +: 2])
      ADD_CL_M1: add = cl - ONE_CYCLE;
      ADD_CL_M2: add = cl - TWO_CYCLES;
      default:   add = '0;
    endcase
    return cas_write_latency + add - LAT_OFFSET;
  endfunction : dtc_term_latency

  // chop decision: fixed by mode register or taken on the fly from the write
  function automatic logic dtc_is_chop(input logic [ADDR_W-1:0] mr0, input logic otf);
    logic [1:0] code;
    code = mr0[BURST_LSB +: 2];
    return (code == BURST_FIXED4) || ((code == BURST_OTF) && otf);
  endfunction : dtc_is_chop

endpackage : dtc_pkg

// file: logic/dtc_link_if.sv
// interface: command and termination control lines between controller and memory
interface dtc_link_if;
  import dtc_pkg::*;

  logic              termination_control_pin;
  logic              wr_cmd;
  logic              chop_otf;
  logic              rd_cmd;
  logic              mrs_cmd;
  logic [1:0]        mrs_sel;
  logic [ADDR_W-1:0] mrs_addr;
  logic              self_refresh;

  modport dram (input termination_control_pin, wr_cmd, chop_otf, rd_cmd,
                input mrs_cmd, mrs_sel, mrs_addr, self_refresh);
  modport mc (output termination_control_pin, wr_cmd, chop_otf, rd_cmd,
              output mrs_cmd, mrs_sel, mrs_addr, self_refresh);
endinterface : dtc_link_if

// file: logic/dtc_dram_end.sv
// memory end: termination on/off timing and dynamic strength selection
module dtc_dram_end
  import dtc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // link from the controller
  dtc_link_if.dram         link,
  // data path status
  input  wire logic        dq_drive_i,
  // termination outputs
  output logic             rtt_on_o,
  output logic             rtt_write_o,
  output logic [2:0]       rtt_value_o,
  output logic             dynamic_en_o,
  output logic [LAT_W-1:0] termination_on_latency_o
);

  // mode register copies
  logic [ADDR_W-1:0] mr0_r;
  logic [ADDR_W-1:0] mr0_nxt;
  logic [ADDR_W-1:0] mr1_r;
  logic [ADDR_W-1:0] mr1_nxt;
  logic [ADDR_W-1:0] mr2_r;
  logic [ADDR_W-1:0] mr2_nxt;

  // delay lines for pin, write and chop
  logic [DEPTH-1:0] pin_hist_r;
  logic [DEPTH-1:0] pin_hist_nxt;
  logic [DEPTH-1:0] wr_hist_r;
  logic [DEPTH-1:0] wr_hist_nxt;
  logic [DEPTH-1:0] chop_hist_r;
  logic [DEPTH-1:0] chop_hist_nxt;

  // strength and output state
  logic [HOLD_W-1:0] wr_rem_r;
  logic [HOLD_W-1:0] wr_rem_nxt;
  dtc_strength_e     str_r;
  dtc_strength_e     str_nxt;
  logic              on_r;
  logic              on_nxt;
  logic [2:0]        value_r;
  logic [2:0]        value_nxt;
  logic [LAT_W-1:0]  lat_r;
  logic [LAT_W-1:0]  lat_nxt;

  // decoded controls
  logic             term_en;
  logic             dyn_en;
  logic [LAT_W-1:0] lat;
  logic [LAT_W-1:0] tap;
  logic             pin_ok;
  logic             wr_arrive;
  logic             chop_arrive;
  logic [2:0]       nom_code;
  logic [2:0]       wr_code;

  // mode register decode and termination latency
  always_comb begin
    term_en  = mr1_r[NOM_B9] | mr1_r[NOM_B6] | mr1_r[NOM_B2] |
               mr2_r[WRS_B10] | mr2_r[WRS_B9];
    dyn_en   = mr2_r[WRS_B10] | mr2_r[WRS_B9];
    nom_code = {mr1_r[NOM_B9], mr1_r[NOM_B6], mr1_r[NOM_B2]};
    wr_code  = {1'b0, mr2_r[WRS_B10], mr2_r[WRS_B9]};
    lat      = dtc_term_latency(mr0_r, mr1_r, mr2_r);
    // the tap sits one stage early since the output flop adds the last cycle
    tap      = lat - ONE_CYCLE;
  end

  // the pin only enters the delay line when termination is usable at all
  assign pin_ok = link.termination_control_pin & term_en & ~link.self_refresh;

  // delayed events at the latency tap
  assign wr_arrive   = wr_hist_r[tap];
  assign chop_arrive = chop_hist_r[tap];

  // mode register set updates
  always_comb begin
    mr0_nxt = mr0_r;
    mr1_nxt = mr1_r;
    mr2_nxt = mr2_r;
    if (link.mrs_cmd) begin
      unique case (link.mrs_sel)
        SEL_MODE0: mr0_nxt = link.mrs_addr;
        SEL_MODE1: mr1_nxt = link.mrs_addr;
        SEL_MODE2: mr2_nxt = link.mrs_addr;
        default:   mr0_nxt = mr0_r;  // the fourth register holds no termination field
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mr0_r <= '0;
      mr1_r <= '0;
      mr2_r <= '0;
    end else begin
      mr0_r <= mr0_nxt;
      mr1_r <= mr1_nxt;
      mr2_r <= mr2_nxt;
    end
  end

  // delay lines: stage 0 holds what was registered at the last edge
  always_comb begin
    pin_hist_nxt  = {pin_hist_r[DEPTH-2:0], pin_ok};
    wr_hist_nxt   = {wr_hist_r[DEPTH-2:0], link.wr_cmd & dyn_en};
    chop_hist_nxt = {chop_hist_r[DEPTH-2:0], dtc_is_chop(mr0_r, link.chop_otf)};
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_hist_r  <= '0;
      wr_hist_r   <= '0;
      chop_hist_r <= '0;
    end else begin
      pin_hist_r  <= pin_hist_nxt;
      wr_hist_r   <= wr_hist_nxt;
      chop_hist_r <= chop_hist_nxt;
    end
  end

  // dynamic strength: write strength for 4 or 6 cycles after the write lands
  always_comb begin
    if (wr_arrive) begin
      // a later write simply restarts the window; back-to-back writes stay on write strength
      wr_rem_nxt = chop_arrive ? MIN_CONTROL_HIGH_SHORT : MIN_CONTROL_HIGH_LONG;
    end else if (wr_rem_r != '0) begin
      wr_rem_nxt = wr_rem_r - 3'h1;
    end else begin
      wr_rem_nxt = '0;
    end
    if (!dyn_en) begin
      wr_rem_nxt = '0;
    end
    str_nxt = (wr_rem_nxt != '0) ? STR_WRITE : STR_NOMINAL;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_rem_r <= '0;
      str_r    <= STR_NOMINAL;
    end else begin
      wr_rem_r <= wr_rem_nxt;
      str_r    <= str_nxt;
    end
  end

  // termination switch and strength code
  always_comb begin
    // termination drops one edge after data drive starts and switches back on one edge after driving ends
    on_nxt = pin_hist_r[tap] & term_en & ~link.self_refresh & ~dq_drive_i;
    value_nxt = '0;
    if (on_nxt) begin
      unique case (str_nxt)
        STR_WRITE:   value_nxt = wr_code;
        STR_NOMINAL: value_nxt = nom_code;
      endcase
    end
    lat_nxt = lat;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      on_r    <= 1'b0;
      value_r <= '0;
      lat_r   <= '0;
    end else begin
      on_r    <= on_nxt;
      value_r <= value_nxt;
      lat_r   <= lat_nxt;
    end
  end

  // outputs straight from flops, except dynamic_en_o, which is decoded from the second mode register copy
  assign rtt_on_o                 = on_r;
  assign rtt_write_o              = (str_r == STR_WRITE);
  assign rtt_value_o              = value_r;
  assign dynamic_en_o             = dyn_en;
  assign termination_on_latency_o = lat_r;

endmodule : dtc_dram_end

// file: testbench/dtc_link_assertions.sv
// checker: link protocol and termination timing of the controller and memory pair
module dtc_link_assertions
  import dtc_pkg::*;
(
  // clock and reset
  input wire logic              core_clk_i,
  input wire logic              nrst_i,
  // link signals
  input wire logic              termination_control_pin,
  input wire logic              wr_cmd,
  input wire logic              chop_otf,
  input wire logic              rd_cmd,
  input wire logic              mrs_cmd,
  input wire logic [1:0]        mrs_sel,
  input wire logic [ADDR_W-1:0] mrs_addr,
  input wire logic              self_refresh,
  // memory end
  input wire logic              dq_drive_i,
  input wire logic              rtt_on_o,
  input wire logic              rtt_write_o,
  input wire logic [LAT_W-1:0]  termination_on_latency_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] QUIET = 6'h28;
  logic [47:0] pin_h_r, pin_h_nxt, wr_h_r, wr_h_nxt;
  logic [5:0]  quiet_r, quiet_nxt, low_r, low_nxt, lat;
  logic [1:0]  burst_r, burst_nxt;
  logic        dyn_r, dyn_nxt, chop;

  // histories indexed by latency; quiet counts edges free of mode, refresh and drive upsets
  always_comb begin
    pin_h_nxt = {pin_h_r[46:0], termination_control_pin};
    wr_h_nxt  = {wr_h_r[46:0], wr_cmd};
    quiet_nxt = (mrs_cmd || self_refresh || dq_drive_i) ? 6'h00 : quiet_r + {5'h00, quiet_r != QUIET};
    low_nxt   = termination_control_pin ? 6'h00 : low_r + {5'h00, low_r != 6'h3f};
    burst_nxt = (mrs_cmd && mrs_sel == SEL_MODE0) ? mrs_addr[1:0] : burst_r;
    dyn_nxt   = (mrs_cmd && mrs_sel == SEL_MODE2) ? (mrs_addr[WRS_B10] | mrs_addr[WRS_B9]) : dyn_r;
  end

  // shadow registers
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_h_r <= '0;
      wr_h_r  <= '0;
      quiet_r <= '0;
      low_r   <= '0;
      burst_r <= '0;
      dyn_r   <= 1'b0;
    end else begin
      pin_h_r <= pin_h_nxt;
      wr_h_r  <= wr_h_nxt;
      quiet_r <= quiet_nxt;
      low_r   <= low_nxt;
      burst_r <= burst_nxt;
      dyn_r   <= dyn_nxt;
    end
  end

  assign lat  = {1'b0, termination_on_latency_o};
  assign chop = (burst_r == BURST_FIXED4) || (burst_r == BURST_OTF && chop_otf);

  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  pin_hold_a: assert property ($rose(termination_control_pin) |-> termination_control_pin [*4])
    else $error("control pin dropped inside minimum high time");
  wr_chop_a: assert property (wr_cmd && termination_control_pin && chop |-> termination_control_pin [*4])
    else $error("control pin dropped early after chopped write");
  wr_burst_a: assert property (wr_cmd && termination_control_pin && !chop |-> termination_control_pin [*6])
    else $error("control pin dropped early after full burst write");
  rd_guard_a: assert property (rd_cmd |-> (low_r >= lat) ##0 (!termination_control_pin) [*5])
    else $error("read issued or guarded with control pin high");
  drive_off_a: assert property (dq_drive_i |=> !rtt_on_o)
    else $error("termination on while data lines driven");
  rtt_follow_a: assert property (quiet_r == QUIET |-> rtt_on_o == pin_h_r[lat])
    else $error("termination state not pin delayed by latency");
  wstr_rise_a: assert property ($rose(rtt_write_o) |-> wr_h_r[lat] && dyn_r)
    else $error("write strength selected without timed write");
  wstr_fall_a: assert property ($fell(rtt_write_o) |-> wr_h_r[lat + 6'h04] || wr_h_r[lat + 6'h06])
    else $error("write strength released at wrong time");

  cov_wr_c: cover property (wr_cmd && termination_control_pin);
  cov_rd_c: cover property (rd_cmd);
  cov_wstr_c: cover property ($fell(rtt_write_o));
endmodule : dtc_link_assertions

// file: testbench/dtc_dram_termination_control_tb_top.sv
// testbench top: controller and memory ends joined over the link, driven through apb
module dtc_dram_termination_control_tb_top
  import dtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] mr0, mr1, mr2;
    logic [4:0]  lat;
    logic [2:0]  nom;
    logic        dyn;
  } dtc_row_s;
  // mode settings beside expected latency, nominal code and dynamic enable
  dtc_row_s rows [3] = '{'{16'h0000, 16'h0004, 16'h0000, 5'h03, 3'h1, 1'b0},
                         '{16'h0010, 16'h0048, 16'h0208, 5'h08, 3'h2, 1'b1},
                         '{16'h0020, 16'h0210, 16'h0410, 5'h09, 3'h4, 1'b1}};
  logic             core_clk_i, nrst_i, psel, penable, pwrite, dq_drive;
  logic             pready, pslverr, rtt_on, rtt_write, dyn_en, sv;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, q;
  logic [2:0]       rtt_value;
  logic [LAT_W-1:0] lat_o;
  logic [5:0]       mon;
  int               err_total, total_checks, n;

  dtc_link_if dtc_link_if_inst ();
  dtc_mc_end dtc_mc_end_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .link(dtc_link_if_inst.mc));
  dtc_dram_end dtc_dram_end_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .link(dtc_link_if_inst.dram),
    .dq_drive_i(dq_drive), .rtt_on_o(rtt_on), .rtt_write_o(rtt_write), .rtt_value_o(rtt_value),
    .dynamic_en_o(dyn_en), .termination_on_latency_o(lat_o));
  dtc_link_assertions dtc_link_assertions_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .termination_control_pin(dtc_link_if_inst.termination_control_pin), .wr_cmd(dtc_link_if_inst.wr_cmd),
    .chop_otf(dtc_link_if_inst.chop_otf), .rd_cmd(dtc_link_if_inst.rd_cmd), .mrs_cmd(dtc_link_if_inst.mrs_cmd),
    .mrs_sel(dtc_link_if_inst.mrs_sel), .mrs_addr(dtc_link_if_inst.mrs_addr),
    .self_refresh(dtc_link_if_inst.self_refresh), .dq_drive_i(dq_drive), .rtt_on_o(rtt_on),
    .rtt_write_o(rtt_write), .termination_on_latency_o(lat_o));

  // monitor bits: 0 pin, 1 on, 2 write strength, 3 write, 4 read, 5 mode set
  assign mon = {dtc_link_if_inst.mrs_cmd, dtc_link_if_inst.rd_cmd, dtc_link_if_inst.wr_cmd, rtt_write, rtt_on,
                dtc_link_if_inst.termination_control_pin};

  // 100 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer; the request holds until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do @(posedge core_clk_i); while (pready !== 1'b1);
    q = prdata;
    sv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic set_mr(input logic [1:0] sel, input logic [15:0] v);
    apb(1'b1, REG_MRS, {14'h0, sel, v});
    apb(1'b1, REG_CMD, 32'h8);
  endtask : set_mr

  // edges until monitor bit w shows v, sampled just after each edge; bounded
  task automatic cnt(input int w, input logic v, output int k);
    #1;
    k = 0;
    while (mon[w] !== v && k < 300) begin
      @(posedge core_clk_i);
      #1;
      k++;
    end
  endtask : cnt

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // watchdog: the whole sequence needs well under this span
  initial begin
    #400000;
    err_total++;
    test_done();
  end

  initial begin
    {nrst_i, psel, penable, pwrite, dq_drive} = '0;
    paddr = '0;
    pwdata = '0;
    err_total = 0;
    total_checks = 0;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk(mon, 6'h00);
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk(lat_o, 5'h03);
    foreach (rows[i]) begin
      set_mr(SEL_MODE0, rows[i].mr0);
      set_mr(SEL_MODE1, rows[i].mr1);
      set_mr(SEL_MODE2, rows[i].mr2);
      apb(1'b1, REG_TIMING, {27'h0, rows[i].lat});
      repeat (45) @(posedge core_clk_i);
      apb(1'b0, REG_TIMING, 32'h0);
      chk(q, {27'h0, rows[i].lat});
      chk(lat_o, rows[i].lat);
      chk(dyn_en, rows[i].dyn);
      apb(1'b1, REG_CTRL, 32'h1);
      cnt(0, 1'b1, n);
      cnt(1, 1'b1, n);
      chk(n, rows[i].lat + 1);
      chk(rtt_value, rows[i].nom);
      chk(rtt_write, 1'b0);
      apb(1'b1, REG_CTRL, 32'h0);
      cnt(0, 1'b0, n);
      cnt(1, 1'b0, n);
      chk(n, rows[i].lat + 1);
    end
    // writes with the pin dropped at once: burst of eight, chop on the fly, fixed chop
    for (int c = 0; c < 3; c++) begin
      set_mr(SEL_MODE0, 16'h0021 + 16'(c / 2));
      apb(1'b1, REG_CTRL, 32'h1);
      cnt(0, 1'b1, n);
      apb(1'b1, REG_CMD, {30'h0, c == 1, 1'b1});
      fork
        apb(1'b1, REG_CTRL, 32'h0);
        begin
          cnt(3, 1'b1, n);
          cnt(2, 1'b1, n);
          chk(n, 10);
          chk(rtt_value, 3'h2);
          cnt(2, 1'b0, n);
          chk(n, (c == 0) ? 6 : 4);
        end
      join
      cnt(1, 1'b0, n);
    end
    apb(1'b0, REG_MRS, 32'h0);
    chk(q, 32'h0000_0022);
    apb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    chk(sv, 1'b1);
    // data drive forces termination off; a read waits for the pin to fall
    apb(1'b1, REG_CTRL, 32'h1);
    cnt(1, 1'b1, n);
    @(posedge core_clk_i);
    dq_drive <= 1'b1;
    cnt(1, 1'b0, n);
    chk(n, 1);
    @(posedge core_clk_i);
    dq_drive <= 1'b0;
    apb(1'b1, REG_CMD, 32'h4);
    cnt(4, 1'b1, n);
    chk(mon[0], 1'b0);
    // self refresh: pin requested but ignored
    apb(1'b1, REG_CTRL, 32'h3);
    repeat (30) @(posedge core_clk_i);
    #1;
    chk(rtt_on, 1'b0);
    // controller still holds the pin high with nothing pending; only the memory ignores it
    apb(1'b0, REG_STATUS, 32'h0);
    chk(q, 32'h0000_0001);
    apb(1'b1, REG_CTRL, 32'h0);
    // loop off clears the write strength bits through a mode set
    apb(1'b1, REG_CTRL, 32'h4);
    cnt(5, 1'b1, n);
    chk(dtc_link_if_inst.mrs_sel, SEL_MODE2);
    chk(dtc_link_if_inst.mrs_addr, 16'h0010);
    repeat (3) @(posedge core_clk_i);
    #1;
    chk(dyn_en, 1'b0);
    // reset in mid-run
    @(posedge core_clk_i);
    nrst_i <= 1'b0;
    #1;
    chk(mon, 6'h00);
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk(lat_o, 5'h03);
    test_done();
  end
endmodule : dtc_dram_termination_control_tb_top
